// *** link_message_unit_defines.svh ***
// constants for the link message unit classifier
`ifndef LINK_MESSAGE_UNIT_DEFINES_SVH
`define LINK_MESSAGE_UNIT_DEFINES_SVH
`define FT_NWRITE 4'h5
`define FT_SWRITE 4'h6
`define FT_PORT_WRITE 4'h8
`define FT_STREAM 4'h9
`define FT_DOORBELL 4'ha
`define FT_MESSAGE 4'hb
`define NUM_RULES 64
`define NUM_CTX 17
`define CTX_IDX_W 5
`define RULE_IDX_W 6
`define QUEUE_W 8
`endif

// *** link_message_unit_pkg.sv ***
// types shared by the link message unit classifier
`default_nettype none
package link_message_unit_pkg;
   // header fields that a rule may look at
   typedef struct packed {
      logic [3:0] ftype;
      logic [1:0] link_port;
      logic [15:0] src_id;
      logic [15:0] dst_id;
      logic [2:0] flow_level;
      logic [7:0] class_of_service;
      logic [15:0] stream_id;
      logic [5:0] mailbox;
      logic first_seg;
      logic last_seg;
   } hdr_t;
   // one classification rule: values, care masks, queue
   typedef struct packed {
      logic enable;
      hdr_t value;
      hdr_t mask;
      logic [7:0] queue;
   } rule_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CLASSIFY = 3'b010,
      ST_ISSUE = 3'b100
   } state_t;
endpackage
`default_nettype wire

// *** rule_matcher.sv ***
// one classification rule compared against one header
`include "link_message_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rule_matcher (
   input wire link_message_unit_pkg::rule_t i_rule, // rule under test
   input wire link_message_unit_pkg::hdr_t i_hdr, // packet header
   output logic o_hit // rule matches header
);
   logic type_ok;
   logic common_ok;
   logic extra_ok;
   // only the four classified types may hit; masks give wildcarding
   always_comb begin
      type_ok = (i_hdr.ftype == `FT_PORT_WRITE) || (i_hdr.ftype == `FT_STREAM) ||
                (i_hdr.ftype == `FT_DOORBELL) || (i_hdr.ftype == `FT_MESSAGE);
      common_ok = (((i_hdr.link_port ^ i_rule.value.link_port) & i_rule.mask.link_port) == '0) &&
                  (((i_hdr.src_id ^ i_rule.value.src_id) & i_rule.mask.src_id) == '0) &&
                  (((i_hdr.dst_id ^ i_rule.value.dst_id) & i_rule.mask.dst_id) == '0) &&
                  (((i_hdr.flow_level ^ i_rule.value.flow_level) & i_rule.mask.flow_level) == '0) &&
                  (((i_hdr.ftype ^ i_rule.value.ftype) & i_rule.mask.ftype) == '0);
      extra_ok = 1'b1;
      if (i_hdr.ftype == `FT_STREAM) begin
         extra_ok = (((i_hdr.class_of_service ^ i_rule.value.class_of_service) &
                      i_rule.mask.class_of_service) == '0) &&
                    (((i_hdr.stream_id ^ i_rule.value.stream_id) & i_rule.mask.stream_id) == '0);
      end else if (i_hdr.ftype == `FT_MESSAGE) begin
         extra_ok = ((i_hdr.mailbox ^ i_rule.value.mailbox) & i_rule.mask.mailbox) == '0;
      end
      o_hit = i_rule.enable && type_ok && common_ok && extra_ok;
   end
endmodule // rule_matcher
`default_nettype wire

// *** link_message_unit.sv ***
// link message unit: ingress classification, reassembly contexts, outbound issue
// Notes on behaviour
// - sends and accepts types 8, 9, 10, 11
// - outbound can originate NWRITE and SWRITE
// - at most 17 open reassembly contexts
// - ingress packet checked against 64 rules
// - rules cover types 8, 9, 10, 11
// - masked wildcard link, source, destination, flow
// - streaming adds class of service, StreamID
// - messaging adds mailbox match
`include "link_message_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module link_message_unit #(
   parameter int NUM_RULES = `NUM_RULES, // classification rule bank size
   parameter int NUM_CTX = `NUM_CTX // reassembly context count
) (
   input wire logic i_ref_clk, // system clock, 25 MHz
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic i_ce, // clock enable, freezes state when low
   input wire logic i_rule_we, // rule write strobe
   input wire logic [`RULE_IDX_W-1:0] i_rule_idx, // rule index to write
   input wire link_message_unit_pkg::rule_t i_rule, // rule contents
   input wire logic [`QUEUE_W-1:0] i_default_queue, // queue when no rule hits
   input wire logic i_in_valid, // ingress header valid
   output logic o_in_ready, // ingress header accepted
   input wire link_message_unit_pkg::hdr_t i_in_hdr, // ingress header
   output logic o_q_valid, // classification result valid
   input wire logic i_q_ready, // queue manager takes result
   output link_message_unit_pkg::hdr_t o_q_hdr, // header passed on
   output logic [`QUEUE_W-1:0] o_q_queue, // destination queue
   output logic o_q_hit, // a rule matched
   output logic [`RULE_IDX_W-1:0] o_q_rule, // winning rule
   output logic o_q_retry, // new message refused, contexts full
   output logic [`CTX_IDX_W-1:0] o_q_ctx, // context used
   output logic [`CTX_IDX_W:0] o_ctx_open, // contexts open now
   input wire logic i_out_valid, // outbound request valid
   output logic o_out_ready, // outbound request taken
   input wire link_message_unit_pkg::hdr_t i_out_hdr, // outbound header
   output logic o_tx_valid, // link transmit valid
   input wire logic i_tx_ready, // link takes packet
   output link_message_unit_pkg::hdr_t o_tx_hdr, // transmit header
   output logic o_tx_bad // outbound request type not supported
);
   // ***************************************************
   // rule bank and context storage
   // ***************************************************
   link_message_unit_pkg::rule_t rules [NUM_RULES];
   logic [NUM_RULES-1:0] hits;
   logic [NUM_CTX-1:0] ctx_busy;
   logic [15:0] ctx_src [NUM_CTX];
   logic [16:0] ctx_key [NUM_CTX];
   link_message_unit_pkg::state_t state;
   link_message_unit_pkg::hdr_t hdr;
   logic first_found;
   logic [`RULE_IDX_W-1:0] first_idx;
   logic ctx_found;
   logic [`CTX_IDX_W-1:0] ctx_idx;
   logic free_found;
   logic [`CTX_IDX_W-1:0] free_idx;
   logic is_multi;
   logic [16:0] hdr_key;
   logic out_ok;

   // rules are written by the configuring agent one at a time
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         for (int r = 0; r < NUM_RULES; r++) begin
            rules[r] <= '0;
         end
      end else if (i_ce && i_rule_we && (int'(i_rule_idx) < NUM_RULES)) begin
         rules[i_rule_idx] <= i_rule;
      end
   end

   // one matcher per rule, all evaluated in parallel
   for (genvar g = 0; g < NUM_RULES; g++) begin : g_rule
      rule_matcher u_match (
         .i_rule(rules[g]),
         .i_hdr(hdr),
         .o_hit(hits[g])
      );
   end

   // ***************************************************
   // priority and context search
   // ***************************************************
   // streams key on stream id, messages on mailbox, both per source
   always_comb begin
      // top bit keeps a stream and a mailbox of equal number in separate contexts
      hdr_key = (hdr.ftype == `FT_STREAM) ? {1'b0, hdr.stream_id} : {1'b1, 10'h000, hdr.mailbox};
      is_multi = (hdr.ftype == `FT_STREAM) || (hdr.ftype == `FT_MESSAGE);
      first_found = 1'b0;
      first_idx = '0;
      // downward scan leaves the lowest hit index in place
      for (int r = NUM_RULES - 1; r >= 0; r--) begin
         if (hits[r]) begin
            first_found = 1'b1;
            first_idx = r[`RULE_IDX_W-1:0];
         end
      end
      ctx_found = 1'b0;
      ctx_idx = '0;
      free_found = 1'b0;
      free_idx = '0;
      for (int c = NUM_CTX - 1; c >= 0; c--) begin
         if (ctx_busy[c] && ctx_src[c] == hdr.src_id && ctx_key[c] == hdr_key) begin
            ctx_found = 1'b1;
            ctx_idx = c[`CTX_IDX_W-1:0];
         end
         if (!ctx_busy[c]) begin
            free_found = 1'b1;
            free_idx = c[`CTX_IDX_W-1:0];
         end
      end
   end

   // ***************************************************
   // ingress state machine
   // ***************************************************
   assign o_in_ready = (state == link_message_unit_pkg::ST_IDLE);

   // one header classified at a time; the result waits for the queue manager
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state <= link_message_unit_pkg::ST_IDLE;
         hdr <= '0;
      end else if (i_ce) begin
         case (state)
            link_message_unit_pkg::ST_IDLE: begin
               if (i_in_valid) begin
                  hdr <= i_in_hdr;
                  state <= link_message_unit_pkg::ST_CLASSIFY;
               end
            end
            link_message_unit_pkg::ST_CLASSIFY: begin
               state <= link_message_unit_pkg::ST_ISSUE;
            end
            link_message_unit_pkg::ST_ISSUE: begin
               if (i_q_ready) begin
                  state <= link_message_unit_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= link_message_unit_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // result registers loaded at the end of classification
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_q_valid <= 1'b0;
         o_q_hdr <= '0;
         o_q_queue <= '0;
         o_q_hit <= 1'b0;
         o_q_rule <= '0;
         o_q_retry <= 1'b0;
         o_q_ctx <= '0;
      end else if (i_ce) begin
         if (state == link_message_unit_pkg::ST_CLASSIFY) begin
            o_q_valid <= 1'b1;
            o_q_hdr <= hdr;
            o_q_hit <= first_found;
            o_q_rule <= first_idx;
            o_q_queue <= first_found ? rules[first_idx].queue : i_default_queue;
            // a new message with no free context is refused, never overlaid
            // single-segment and closing segments need no context, so they are never refused
            o_q_retry <= is_multi && !ctx_found && !free_found && !hdr.last_seg;
            o_q_ctx <= ctx_found ? ctx_idx : free_idx;
         end else if (state == link_message_unit_pkg::ST_ISSUE && i_q_ready) begin
            o_q_valid <= 1'b0;
         end
      end
   end

   // contexts open on a stream or message non-last segment that finds no context and a free one, close on the last
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ctx_busy <= '0;
         for (int c = 0; c < NUM_CTX; c++) begin
            ctx_src[c] <= '0;
            ctx_key[c] <= '0;
         end
      end else if (i_ce && state == link_message_unit_pkg::ST_CLASSIFY && is_multi) begin
         if (ctx_found) begin
            if (hdr.last_seg) begin
               ctx_busy[ctx_idx] <= 1'b0;
            end
         end else if (free_found && !hdr.last_seg) begin
            ctx_busy[free_idx] <= 1'b1;
            ctx_src[free_idx] <= hdr.src_id;
            ctx_key[free_idx] <= hdr_key;
         end
      end
   end

   // open context count for monitoring
   always_comb begin
      o_ctx_open = '0;
      for (int c = 0; c < NUM_CTX; c++) begin
         o_ctx_open = o_ctx_open + {{`CTX_IDX_W{1'b0}}, ctx_busy[c]};
      end
   end

   // ***************************************************
   // outbound path
   // ***************************************************
   // supported outbound types; others are reported and dropped
   always_comb begin
      out_ok = (i_out_hdr.ftype == `FT_NWRITE) || (i_out_hdr.ftype == `FT_SWRITE) ||
               (i_out_hdr.ftype == `FT_PORT_WRITE) || (i_out_hdr.ftype == `FT_STREAM) ||
               (i_out_hdr.ftype == `FT_DOORBELL) || (i_out_hdr.ftype == `FT_MESSAGE);
   end

   assign o_out_ready = !o_tx_valid;

   // single-entry transmit holding register
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_tx_valid <= 1'b0;
         o_tx_hdr <= '0;
         o_tx_bad <= 1'b0;
      end else if (i_ce) begin
         o_tx_bad <= 1'b0;
         if (o_tx_valid && i_tx_ready) begin
            o_tx_valid <= 1'b0;
         end else if (!o_tx_valid && i_out_valid) begin
            o_tx_valid <= out_ok;
            o_tx_hdr <= i_out_hdr;
            o_tx_bad <= !out_ok;
         end
      end
   end
endmodule // link_message_unit
`default_nettype wire

// *** ready_model.sv ***
// queue manager or link side acceptor that stalls a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module ready_model (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_valid, // offered item valid
   input wire logic [2:0] i_wait, // stall cycles before taking
   output logic o_ready // item taken at this edge
);
   logic [2:0] cnt;
   // ready rises after the stall and drops at once after the take, never holding early
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_valid || o_ready) begin
         cnt <= 3'h0;
         o_ready <= 1'b0;
      end else begin
         cnt <= cnt + 3'h1;
         o_ready <= (cnt >= i_wait);
      end
   end
endmodule // ready_model
`default_nettype wire

// *** link_message_unit_properties.sv ***
// timing checks on the link message unit ports
`timescale 1ns/1ps
`default_nettype none
module link_message_unit_properties #(
   parameter int NUM_CTX = 17 // reassembly context count
) (
   input wire logic i_ref_clk, // clock
   input wire logic i_rst_n, // sync reset
   input wire logic i_ce, // clock enable
   input wire logic i_in_valid, // ingress valid
   input wire logic o_in_ready, // ingress ready
   input wire logic o_q_valid, // result valid
   input wire logic i_q_ready, // result taken
   input wire logic o_q_retry, // new message refused
   input wire logic [5:0] o_ctx_open, // open contexts
   input wire logic i_out_valid, // outbound valid
   input wire logic o_out_ready, // outbound ready
   input wire link_message_unit_pkg::hdr_t i_out_hdr, // outbound header
   input wire logic o_tx_valid, // transmit valid
   input wire logic i_tx_ready, // transmit taken
   input wire link_message_unit_pkg::hdr_t o_tx_hdr, // transmit header
   input wire logic o_tx_bad // unsupported pulse
);
   // ****************
   // properties
   // ****************
   // a low clock enable freezes the unit, so checks pause with it
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n || !i_ce);
   logic out_ok;
   assign out_ok = i_out_hdr.ftype inside {4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb};
   sequence seq_take;
      i_in_valid && o_in_ready;
   endsequence
   sequence seq_send;
      i_out_valid && o_out_ready;
   endsequence
   AST_ANSWER: assert property (seq_take |=> !o_q_valid ##1 o_q_valid)
      else $error("result not two cycles after take");
   AST_HOLD: assert property (o_q_valid && !i_q_ready |=> o_q_valid && $stable(o_q_retry))
      else $error("result dropped before taken");
   AST_BUSY: assert property (o_q_valid |-> !o_in_ready)
      else $error("ingress ready while result pending");
   AST_CTX_MAX: assert property (o_ctx_open <= NUM_CTX)
      else $error("too many open contexts");
   AST_RETRY_FULL: assert property (o_q_valid && o_q_retry |-> o_ctx_open == NUM_CTX)
      else $error("retry without full contexts");
   AST_TX_NEXT: assert property (seq_send and out_ok |=> o_tx_valid && o_tx_hdr == $past(i_out_hdr))
      else $error("supported request not sent next cycle");
   AST_TX_BAD: assert property (seq_send and !out_ok |=> o_tx_bad && !o_tx_valid)
      else $error("unsupported request not flagged");
   AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_hdr))
      else $error("transmit changed before taken");
endmodule // link_message_unit_properties
bind link_message_unit link_message_unit_properties #(.NUM_CTX(NUM_CTX)) u_props (.i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n), .i_ce(i_ce), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .o_q_valid(o_q_valid),
   .i_q_ready(i_q_ready), .o_q_retry(o_q_retry), .o_ctx_open(o_ctx_open), .i_out_valid(i_out_valid),
   .o_out_ready(o_out_ready), .i_out_hdr(i_out_hdr), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
   .o_tx_hdr(o_tx_hdr), .o_tx_bad(o_tx_bad));
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the link message unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end
module testbench;
   typedef struct packed {link_message_unit_pkg::hdr_t h; logic [7:0] q; logic hit; logic [5:0] r;} row_t;
   logic clk, rst_n, rule_we, in_valid, in_ready, q_valid, q_ready, q_hit, q_retry, out_valid, out_ready;
   logic tx_valid, tx_ready, tx_bad, ce;
   logic [5:0] rule_idx, q_rule, ctx_open;
   logic [4:0] q_ctx;
   logic [7:0] q_queue;
   logic [2:0] q_wait;
   link_message_unit_pkg::rule_t rule;
   link_message_unit_pkg::hdr_t in_hdr, q_hdr, out_hdr, tx_hdr, z, f;
   row_t rows[10];
   row_t g;
   int n_errors = 0;
   int checks_done = 0;
   link_message_unit DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_rule_we(rule_we),
      .i_rule_idx(rule_idx), .i_rule(rule), .i_default_queue(8'hee), .i_in_valid(in_valid), .o_in_ready(in_ready),
      .i_in_hdr(in_hdr), .o_q_valid(q_valid), .i_q_ready(q_ready), .o_q_hdr(q_hdr), .o_q_queue(q_queue),
      .o_q_hit(q_hit), .o_q_rule(q_rule), .o_q_retry(q_retry), .o_q_ctx(q_ctx), .o_ctx_open(ctx_open),
      .i_out_valid(out_valid), .o_out_ready(out_ready), .i_out_hdr(out_hdr), .o_tx_valid(tx_valid),
      .i_tx_ready(tx_ready), .o_tx_hdr(tx_hdr), .o_tx_bad(tx_bad));
   ready_model u_qm (.i_clk(clk), .i_rst_n(rst_n), .i_valid(q_valid), .i_wait(q_wait), .o_ready(q_ready));
   ready_model u_link (.i_clk(clk), .i_rst_n(rst_n), .i_valid(tx_valid), .i_wait(3'h3), .o_ready(tx_ready));
   // ****************
   // helpers
   // ****************
   function automatic link_message_unit_pkg::hdr_t mk(input logic [3:0] ft, input logic [1:0] lp,
         input logic [15:0] src, dst, input logic [2:0] fl, input logic [7:0] cs, input logic [15:0] sid,
         input logic [5:0] mb, input logic fs, ls);
      mk = '{ft, lp, src, dst, fl, cs, sid, mb, fs, ls};
   endfunction
   // leaves the strobe high so back to back writes never touch it twice in one step
   task automatic put_rule(input logic [5:0] idx, input link_message_unit_pkg::hdr_t v, m, input logic [7:0] q);
      @(negedge clk);
      rule_we = 1'b1;
      rule_idx = idx;
      rule = '{1'b1, v, m, q};
      @(posedge clk);
   endtask
   // one ingress header; result captured while it stands, then wait for the take
   task automatic send(input link_message_unit_pkg::hdr_t h);
      @(negedge clk);
      in_valid = 1'b1;
      in_hdr = h;
      @(negedge clk);
      in_valid = 1'b0;
      for (int i = 0; i < 20 && q_valid !== 1'b1; i++) @(negedge clk);
      `CHK(q_valid, 1'b1)
      g = '{q_hdr, q_queue, q_hit, q_rule};
      for (int i = 0; i < 20 && q_valid !== 1'b0; i++) @(negedge clk);
      `CHK(q_valid, 1'b0)
   endtask
   task automatic send_out(input link_message_unit_pkg::hdr_t h, input logic ok);
      @(negedge clk);
      out_valid = 1'b1;
      out_hdr = h;
      @(negedge clk);
      out_valid = 1'b0;
      `CHK(tx_valid, ok)
      `CHK(tx_bad, !ok)
      if (ok) `CHK(tx_hdr, h)
      for (int i = 0; i < 20 && tx_valid !== 1'b0; i++) @(negedge clk);
      `CHK(tx_valid, 1'b0)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #(3000 * 40);
      n_errors++;
      tally_and_finish;
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      {rst_n, rule_we, in_valid, out_valid} = 4'h0;
      ce = 1'b1;
      rule_idx = 6'h00;
      q_wait = 3'h0;
      z = '0;
      f = '1;
      rule = '0;
      in_hdr = '0;
      out_hdr = '0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      `CHK({in_ready, out_ready, q_valid, tx_valid, ctx_open}, 10'h300)
      put_rule(6'h02, mk(4'h9, 0, 0, 0, 0, 8'h05, 16'h0077, 0, 0, 0),
         mk(4'hf, 0, 0, 0, 0, 8'hff, f.stream_id, 0, 0, 0), 8'h20);
      put_rule(6'h04, mk(0, 2, 0, 16'h0099, 3, 0, 0, 0, 0, 0), mk(0, 3, 0, f.dst_id, 7, 0, 0, 0, 0, 0), 8'h44);
      put_rule(6'h05, mk(4'hb, 0, 0, 0, 0, 0, 0, 3, 0, 0), mk(4'hf, 0, 0, 0, 0, 0, 0, 6'h3f, 0, 0), 8'h30);
      put_rule(6'h07, mk(0, 0, 16'h0011, 0, 0, 0, 0, 0, 0, 0), mk(0, 0, f.src_id, 0, 0, 0, 0, 0, 0, 0), 8'h40);
      put_rule(6'h09, z, z, 8'h50);
      @(negedge clk);
      rule_we = 1'b0;
      rows = '{'{mk(4'h9, 0, 16'h0011, 0, 0, 8'h05, 16'h0077, 0, 1, 1), 8'h20, 1, 2},
         '{mk(4'h9, 0, 16'h0011, 0, 0, 8'h06, 16'h0077, 0, 1, 1), 8'h40, 1, 7},
         '{mk(4'h9, 0, 16'h0022, 0, 0, 8'h05, 16'h0078, 0, 1, 1), 8'h50, 1, 9},
         '{mk(4'hb, 0, 16'h0022, 0, 0, 0, 0, 3, 1, 1), 8'h30, 1, 5},
         '{mk(4'hb, 0, 16'h0011, 0, 0, 0, 0, 4, 1, 1), 8'h40, 1, 7},
         '{mk(4'h8, 0, 16'h0011, 0, 0, 0, 0, 0, 1, 1), 8'h40, 1, 7},
         '{mk(4'ha, 2, 16'h0022, 16'h0099, 3, 0, 0, 0, 1, 1), 8'h44, 1, 4},
         '{mk(4'ha, 2, 16'h0022, 16'h0099, 2, 0, 0, 0, 1, 1), 8'h50, 1, 9},
         '{mk(4'ha, 1, 16'h0022, 16'h0099, 3, 0, 0, 0, 1, 1), 8'h50, 1, 9},
         '{mk(4'h5, 0, 16'h0011, 0, 0, 0, 0, 0, 1, 1), 8'hee, 0, 0}};
      // the queue side stalls 0 to 3 cycles, the length repeating every four rows
      foreach (rows[i]) begin
         q_wait = 3'(i % 4);
         send(rows[i].h);
         if (rows[i].hit) `CHK(g[14:0], rows[i][14:0])
         else `CHK(g[14:6], rows[i][14:6])
         `CHK(g.h, rows[i].h)
      end
      // fill every context with a mix of streams and messages, then one more
      for (int i = 0; i < 17; i++) begin
         send(mk(i[0] ? 4'hb : 4'h9, 0, 16'h0033, 0, 0, 0, 16'(i), 6'(i), 1, 0));
         `CHK({q_retry, ctx_open}, 7'(i + 1))
         `CHK(q_ctx, 5'(i))
      end
      send(mk(4'h9, 0, 16'h0033, 0, 0, 0, 16'h00ff, 0, 1, 0));
      `CHK({q_retry, ctx_open}, 7'h51)
      // a single-segment stream needs no context, so a full table must not refuse it
      send(mk(4'h9, 0, 16'h0033, 0, 0, 0, 16'h00fe, 0, 1, 1));
      `CHK({q_retry, ctx_open}, 7'h11)
      send(mk(4'h9, 0, 16'h0033, 0, 0, 0, 16'h0000, 0, 0, 1));
      `CHK({q_retry, ctx_open}, 7'h10)
      for (int t = 0; t < 16; t++) begin
         send_out(mk(4'(t), 0, 16'(t), 0, 0, 0, 0, 0, 1, 1), 4'(t) inside {4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb});
      end
      // a second reset must close all contexts and disable every rule
      @(negedge clk);
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      `CHK(ctx_open, 6'h00)
      send(mk(4'h8, 0, 16'h0011, 0, 0, 0, 0, 0, 1, 1));
      `CHK({g.q, g.hit}, 9'h1dc)
      // a low enable freezes the unit even with a request standing at its input
      @(negedge clk);
      ce = 1'b0;
      in_valid = 1'b1;
      in_hdr = mk(4'h9, 0, 16'h0044, 0, 0, 0, 16'h0001, 0, 1, 0);
      repeat (3) @(negedge clk);
      `CHK({q_valid, in_ready, ctx_open}, 8'h40)
      in_valid = 1'b0;
      ce = 1'b1;
      tally_and_finish;
   end
endmodule // testbench
`undef CHK
`default_nettype wire
